// [rtl/mask_override_pkg.sv]
// Constants and carrier types for the mask-override and table-base registers
package mask_override_pkg;
  // Coprocessor register selectors (crn, op1, crm, op2)
  localparam logic [3:0] SEL_MO_CRN = 4'h1;
  localparam logic [3:0] SEL_MO_CRM = 4'h1;
  localparam logic [2:0] SEL_MO_OP2 = 3'h3;
  localparam logic [3:0] SEL_TB_CRN = 4'h2;
  localparam logic [3:0] SEL_TB_CRM = 4'h0;
  localparam logic [2:0] SEL_TB_OP2 = 3'h0;
  localparam logic [2:0] SEL_OP1 = 3'h0;
  // Mask-override fields
  localparam int ABORT_OVR_BIT = 8;
  localparam int IRQ_OVR_BIT = 7;
  localparam int FIQ_OVR_BIT = 6;
  localparam logic [31:0] MO_WRITE_MASK = 32'h0000_01c0;
  localparam logic [31:0] MO_RESET = 32'h0000_0000;
  // Table-base fields
  localparam int TB_ADDR_LO = 7;
  localparam int TB_ADDR_TOP = 14;
  localparam int TB_INNER_LO_BIT = 6;
  localparam int TB_OUTER_LO = 3;
  localparam int TB_SHARE_BIT = 1;
  localparam int TB_INNER_HI_BIT = 0;
  // Bits 31:7, 6, 4:3, 1, 0 stored; 5 and 2 dropped
  localparam logic [31:0] TB_WRITE_MASK = 32'hffff_ffdb;
  localparam logic [31:0] TB_RESET = 32'h0000_0000;
  localparam int SPLIT_MAX = 7;
  // Walk cacheability encodings
  localparam logic [1:0] ATTR_NC = 2'h0;
  localparam logic [1:0] ATTR_WBWA = 2'h1;
  localparam logic [1:0] ATTR_WT = 2'h2;
  localparam logic [1:0] ATTR_WBNA = 2'h3;
  // Processor mode code for user mode
  localparam logic [4:0] MODE_USER = 5'h10;

  typedef struct packed {
    logic valid;
    logic write;
    logic [2:0] op1;
    logic [3:0] crn;
    logic [3:0] crm;
    logic [2:0] op2;
    logic [31:0] wdata;
  } cp_req_t;

  typedef struct packed {
    logic valid;
    logic undef;
    logic [31:0] rdata;
  } cp_resp_t;

  typedef struct packed {
    logic ext_abort_routing;
    logic irq_routing;
    logic fiq_routing;
    logic abort_mask;
    logic irq_mask;
    logic fiq_mask;
  } route_mask_t;

  typedef struct packed {
    logic [31:0] base;
    logic [1:0] outer_walk_attr;
    logic [1:0] inner_walk_attr;
    logic inner_lookup;
    logic shared;
  } walk_cfg_t;
endpackage

// [rtl/mask_override_and_table_base0.sv]
// Mask-override and banked table-base-0 coprocessor registers
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// R1: Mask override reachable only Secure privileged
// R2: Non-secure abort override beats abort mask
// R3: Abort override ignored Secure or routing clear
// R4: Non-secure IRQ override beats IRQ mask
// R5: IRQ override ignored Secure or routing clear
// R6: Non-secure FIQ override beats FIQ mask
// R7: FIQ override ignored Secure or routing clear
// R8: Banked Secure and Non-secure table base
// R9: Secure write while disabled raises Undefined
// R10: Write stores address bits 31 to 7
// R11: Read returns full stored address bits
// R12: Walk uses bits 31 to 14-split
// R13: Outer attribute field encodes outer cacheability
// R14: Inner attribute from bits 0 and 6
// R15: Only write-back walks look up cache
// R16: Shareability bit picks shared walk target
// R17: Bit 2 ignored, software writes zero
// R18: Illegal mask-override access raises Undefined
module mask_override_and_table_base0
  import mask_override_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire mask_override_pkg::cp_req_t req,
  output mask_override_pkg::cp_resp_t resp,
  input wire logic nonsecure,
  input wire logic [4:0] cpu_mode,
  input wire logic secure_write_disable,
  input wire logic [2:0] split_n,
  input wire mask_override_pkg::route_mask_t route_mask,
  input wire logic abort_pending,
  input wire logic irq_pending,
  input wire logic fiq_pending,
  output logic take_abort,
  output logic take_irq,
  output logic take_fiq,
  output mask_override_pkg::walk_cfg_t walk_cfg
);
  import mask_override_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Decode
  logic [31:0] mask_override;
  logic [31:0] tb_secure;
  logic [31:0] tb_nonsecure;
  logic sync_disable_a;
  logic sync_disable;

  wire privileged = (cpu_mode != MODE_USER);
  wire hit_mo = req.valid && req.op1 == SEL_OP1 && req.crn == SEL_MO_CRN &&
                req.crm == SEL_MO_CRM && req.op2 == SEL_MO_OP2;
  wire hit_tb = req.valid && req.op1 == SEL_OP1 && req.crn == SEL_TB_CRN &&
                req.crm == SEL_TB_CRM && req.op2 == SEL_TB_OP2;
  wire mo_legal = privileged && !nonsecure; // R1
  wire mo_undef = hit_mo && !mo_legal; // R18
  wire tb_wr_blocked = req.write && !nonsecure && sync_disable; // R9
  wire tb_undef = hit_tb && (!privileged || tb_wr_blocked);
  wire unmapped = req.valid && !hit_mo && !hit_tb;
  wire any_undef = mo_undef || tb_undef || unmapped;
  wire wr_mo = hit_mo && req.write && !mo_undef;
  wire wr_tb = hit_tb && req.write && !tb_undef;
  wire [31:0] tb_current = nonsecure ? tb_nonsecure : tb_secure; // R8
  wire [31:0] next_mo = req.wdata & MO_WRITE_MASK;
  wire [31:0] next_tb = req.wdata & TB_WRITE_MASK; // R10 R17
  wire [31:0] rd_value = hit_mo ? mask_override : tb_current; // R11

  ////////////////////////////////////////////////////////////////////////////
  // Disable pin is asynchronous to the core, so it is synchronised
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sync_disable_a <= 1'b0;
      sync_disable <= 1'b0;
    end else begin
      sync_disable_a <= secure_write_disable;
      sync_disable <= sync_disable_a;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      mask_override <= MO_RESET;
    end else if (wr_mo) begin
      mask_override <= next_mo; // R1
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      tb_secure <= TB_RESET;
      tb_nonsecure <= TB_RESET;
    end else if (wr_tb) begin
      if (nonsecure) begin
        tb_nonsecure <= next_tb; // R8
      end else begin
        tb_secure <= next_tb; // R8
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      resp <= '0;
    end else begin
      resp.valid <= req.valid;
      resp.undef <= any_undef;
      resp.rdata <= (req.valid && !req.write && !any_undef) ? rd_value
                                                             : 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Exception gating
  // Channel order in the vectors: abort, then IRQ, then FIQ
  wire [2:0] ovr_bits = mask_override[ABORT_OVR_BIT:FIQ_OVR_BIT];
  wire [2:0] routing = {route_mask.ext_abort_routing, route_mask.irq_routing,
                        route_mask.fiq_routing};
  wire [2:0] masked = {route_mask.abort_mask, route_mask.irq_mask,
                       route_mask.fiq_mask};
  wire [2:0] pending = {abort_pending, irq_pending, fiq_pending};
  wire [2:0] force_take;
  wire [2:0] next_take;
  logic [2:0] take;

  // Secure state or clear routing leaves the status-register mask in charge
  for (genvar g = 0; g < 3; g++) begin : gen_gate
    assign force_take[g] = nonsecure && routing[g] && ovr_bits[g]; // R3 R5 R7
    assign next_take[g] = pending[g] &&
                          (!masked[g] || force_take[g]); // R2 R4 R6
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      take <= 3'h0;
    end else begin
      take <= next_take;
    end
  end

  assign take_abort = take[2];
  assign take_irq = take[1];
  assign take_fiq = take[0];

  ////////////////////////////////////////////////////////////////////////////
  // Walk configuration from the copy of the current state
  logic [31:0] walk_mask;
  always_comb begin
    walk_mask = 32'hffff_ffff << (TB_ADDR_TOP - int'(split_n)); // R12
  end
  wire [1:0] inner = {tb_current[TB_INNER_HI_BIT],
                      tb_current[TB_INNER_LO_BIT]}; // R14
  // Write-through walks bypass the cache like non-cacheable ones
  wire inner_wb = (inner == ATTR_WBWA) || (inner == ATTR_WBNA); // R15

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      walk_cfg <= '0;
    end else begin
      walk_cfg.base <= tb_current & walk_mask; // R12
      walk_cfg.outer_walk_attr <= tb_current[TB_OUTER_LO +: 2]; // R13
      walk_cfg.inner_walk_attr <= inner; // R14
      walk_cfg.inner_lookup <= inner_wb; // R15
      walk_cfg.shared <= tb_current[TB_SHARE_BIT]; // R16
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  AST_MO_ILLEGAL: assert property (@(posedge clk_sys) disable iff (rst) // R18
    hit_mo && req.write && (nonsecure || !privileged)
    |=> resp.undef && $stable(mask_override))
    else $error("illegal mask-override write not refused");
  AST_MO_LEGAL: assert property (@(posedge clk_sys) disable iff (rst) // R1
    hit_mo && req.write && privileged && !nonsecure
    |=> !resp.undef && mask_override == $past(next_mo))
    else $error("legal mask-override write lost");
  AST_ABORT: assert property (@(posedge clk_sys) disable iff (rst) // R2
    abort_pending && nonsecure && route_mask.ext_abort_routing &&
    mask_override[ABORT_OVR_BIT] |=> take_abort)
    else $error("abort override not taken");
  AST_ABORT_IGN: assert property (@(posedge clk_sys) disable iff (rst) // R3
    route_mask.abort_mask && (!nonsecure || !route_mask.ext_abort_routing)
    |=> !take_abort)
    else $error("abort override not ignored");
  AST_IRQ: assert property (@(posedge clk_sys) disable iff (rst) // R4
    irq_pending && nonsecure && route_mask.irq_routing &&
    mask_override[IRQ_OVR_BIT] |=> take_irq)
    else $error("irq override not taken");
  AST_IRQ_IGN: assert property (@(posedge clk_sys) disable iff (rst) // R5
    route_mask.irq_mask && (!nonsecure || !route_mask.irq_routing)
    |=> !take_irq)
    else $error("irq override not ignored");
  AST_FIQ: assert property (@(posedge clk_sys) disable iff (rst) // R6
    fiq_pending && nonsecure && route_mask.fiq_routing &&
    mask_override[FIQ_OVR_BIT] |=> take_fiq)
    else $error("fiq override not taken");
  AST_FIQ_IGN: assert property (@(posedge clk_sys) disable iff (rst) // R7
    route_mask.fiq_mask && (!nonsecure || !route_mask.fiq_routing)
    |=> !take_fiq)
    else $error("fiq override not ignored");

  sequence tb_secure_write_blocked;
    hit_tb && req.write && privileged && !nonsecure && sync_disable;
  endsequence
  AST_TB_DISABLE: assert property (@(posedge clk_sys) disable iff (rst) // R9
    tb_secure_write_blocked |=> resp.undef && $stable(tb_secure))
    else $error("disabled secure table-base write not refused");
  AST_TB_BANK: assert property (@(posedge clk_sys) disable iff (rst) // R8
    wr_tb && nonsecure |=> $stable(tb_secure)
    && tb_nonsecure == $past(next_tb))
    else $error("table-base bank crossed");
  AST_TB_BIT2: assert property (@(posedge clk_sys) disable iff (rst) // R17
    !tb_secure[2] && !tb_nonsecure[2])
    else $error("table-base bit 2 stored");
  AST_TB_READ: assert property (@(posedge clk_sys) disable iff (rst) // R11
    hit_tb && !req.write && privileged
    |=> resp.rdata[31:TB_ADDR_LO] == $past(tb_current[31:TB_ADDR_LO]))
    else $error("table-base read lost address bits");
  AST_WALK_WT: assert property (@(posedge clk_sys) disable iff (rst) // R15
    inner == ATTR_WT |=> !walk_cfg.inner_lookup)
    else $error("write-through walk looked up cache");
  AST_WALK_SHARE: assert property (@(posedge clk_sys) disable iff (rst) // R16
    ##1 walk_cfg.shared == $past(tb_current[TB_SHARE_BIT]))
    else $error("walk shareability wrong");
  AST_WALK_ALIGN: assert property (@(posedge clk_sys) disable iff (rst) // R12
    ##1 walk_cfg.base[TB_ADDR_LO-1:0] == 7'h00)
    else $error("walk base carries low bits");
  AST_WALK_OUTER: assert property (@(posedge clk_sys) disable iff (rst) // R13
    ##1 walk_cfg.outer_walk_attr == $past(tb_current[4:3]))
    else $error("outer walk attribute wrong");

  ////////////////////////////////////////////////////////////////////////////
  // Request and answer sequences, then access, walk and exception checks
  sequence mo_read_legal;
    hit_mo && !req.write && privileged && !nonsecure;
  endsequence
  sequence mo_access_nonsecure;
    hit_mo && nonsecure;
  endsequence
  sequence mo_access_user;
    hit_mo && !privileged;
  endsequence
  sequence tb_write_secure;
    wr_tb && !nonsecure;
  endsequence
  sequence tb_write_nonsecure;
    wr_tb && nonsecure;
  endsequence
  sequence tb_write_nonsecure_disabled;
    hit_tb && req.write && privileged && nonsecure && sync_disable;
  endsequence
  // A refused access answers with the flag raised and no data
  sequence answer_refused;
    resp.valid && resp.undef && resp.rdata == 32'h0000_0000;
  endsequence
  sequence answer_accepted;
    resp.valid && !resp.undef;
  endsequence

  AST_MO_READ: assert property (@(posedge clk_sys) disable iff (rst) // R1
    mo_read_legal |=> answer_accepted ##0
    resp.rdata == $past(mask_override))
    else $error("mask-override read lost");
  AST_MO_NS: assert property (@(posedge clk_sys) disable iff (rst) // R18
    mo_access_nonsecure |=> answer_refused)
    else $error("non-secure mask-override access not refused");
  AST_MO_USER: assert property (@(posedge clk_sys) disable iff (rst) // R18
    mo_access_user |=> answer_refused ##0 $stable(mask_override))
    else $error("user mask-override access not refused");

  AST_TB_STORE_S: assert property (@(posedge clk_sys) disable iff (rst) // R10
    tb_write_secure
    |=> tb_secure[31:TB_ADDR_LO] == $past(req.wdata[31:TB_ADDR_LO]))
    else $error("secure table address not stored");
  AST_TB_STORE_NS: assert property (@(posedge clk_sys) disable iff (rst) // R10
    tb_write_nonsecure
    |=> tb_nonsecure[31:TB_ADDR_LO] == $past(req.wdata[31:TB_ADDR_LO]))
    else $error("non-secure table address not stored");
  AST_TB_BANK_S: assert property (@(posedge clk_sys) disable iff (rst) // R8
    tb_write_secure |=> $stable(tb_nonsecure))
    else $error("non-secure table base hit by secure write");
  AST_TB_READ_S: assert property (@(posedge clk_sys) disable iff (rst) // R8
    hit_tb && !req.write && privileged && !nonsecure
    |=> resp.rdata == $past(tb_secure))
    else $error("secure table-base read wrong");
  AST_TB_READ_NS: assert property (@(posedge clk_sys) disable iff (rst) // R8
    hit_tb && !req.write && privileged && nonsecure
    |=> resp.rdata == $past(tb_nonsecure))
    else $error("non-secure table-base read wrong");

  AST_TB_NS_OPEN: assert property (@(posedge clk_sys) disable iff (rst) // R9
    tb_write_nonsecure_disabled |=> answer_accepted)
    else $error("non-secure table-base write refused");
  AST_TB_REFUSED: assert property (@(posedge clk_sys) disable iff (rst) // R9
    tb_secure_write_blocked |=> answer_refused)
    else $error("blocked write answered with data");

  AST_WALK_TOP: assert property (@(posedge clk_sys) disable iff (rst) // R12
    ##1 walk_cfg.base[31:TB_ADDR_TOP] == $past(tb_current[31:TB_ADDR_TOP]))
    else $error("walk base lost address bits");
  AST_WALK_SPLIT0: assert property (@(posedge clk_sys) disable iff (rst) // R12
    split_n == 3'h0 |=> walk_cfg.base[TB_ADDR_TOP-1:0] == 14'h0000)
    else $error("walk base not aligned for split zero");
  AST_WALK_SPLIT7: assert property (@(posedge clk_sys) disable iff (rst) // R12
    split_n == 3'h7 |=> walk_cfg.base[TB_ADDR_TOP-1:TB_ADDR_LO] ==
    $past(tb_current[TB_ADDR_TOP-1:TB_ADDR_LO]))
    else $error("walk base dropped bits for split seven");
  AST_WALK_INNER: assert property (@(posedge clk_sys) disable iff (rst) // R14
    ##1 walk_cfg.inner_walk_attr == {$past(tb_current[TB_INNER_HI_BIT]),
    $past(tb_current[TB_INNER_LO_BIT])})
    else $error("inner walk attribute wrong");
  AST_WALK_WB: assert property (@(posedge clk_sys) disable iff (rst) // R15
    tb_current[TB_INNER_LO_BIT] |=> walk_cfg.inner_lookup)
    else $error("write-back walk skipped the cache");
  AST_WALK_NC: assert property (@(posedge clk_sys) disable iff (rst) // R15
    !tb_current[TB_INNER_LO_BIT] |=> !walk_cfg.inner_lookup)
    else $error("non-cacheable walk looked up cache");

  AST_ABORT_CLEAR: assert property (@(posedge clk_sys) disable iff (rst) // R2
    route_mask.abort_mask && !mask_override[ABORT_OVR_BIT] |=> !take_abort)
    else $error("abort taken with override clear");
  AST_IRQ_CLEAR: assert property (@(posedge clk_sys) disable iff (rst) // R4
    route_mask.irq_mask && !mask_override[IRQ_OVR_BIT] |=> !take_irq)
    else $error("irq taken with override clear");
  AST_FIQ_CLEAR: assert property (@(posedge clk_sys) disable iff (rst) // R6
    route_mask.fiq_mask && !mask_override[FIQ_OVR_BIT] |=> !take_fiq)
    else $error("fiq taken with override clear");
  AST_ABORT_NONE: assert property (@(posedge clk_sys) disable iff (rst) // R2
    !abort_pending |=> !take_abort)
    else $error("abort taken with nothing pending");
  AST_IRQ_NONE: assert property (@(posedge clk_sys) disable iff (rst) // R4
    !irq_pending |=> !take_irq)
    else $error("irq taken with nothing pending");
  AST_FIQ_NONE: assert property (@(posedge clk_sys) disable iff (rst) // R6
    !fiq_pending |=> !take_fiq)
    else $error("fiq taken with nothing pending");
endmodule

`default_nettype wire

// [test/mask_override_and_table_base0_tb.sv]
// Self-checking testbench for the mask-override and table-base registers
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin \
  num_errors++; $display("wrong value at %0t: got %h want %h", $time, \
  got, exp); end end

module mask_override_and_table_base0_tb;
  import mask_override_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  cp_req_t req = '0;
  cp_resp_t resp;
  logic nonsecure = 1'b0;
  logic [4:0] cpu_mode = 5'h13;
  logic secure_write_disable = 1'b0;
  logic [2:0] split_n = 3'h0;
  route_mask_t route_mask = '0;
  logic [2:0] pending = 3'h0;
  logic take_abort;
  logic take_irq;
  logic take_fiq;
  walk_cfg_t walk_cfg;
  int num_errors = 0;
  int comparisons = 0;
  int cycles = 0;
  // Rows: nonsecure, routing, masks, overrides, expected takes
  logic [12:0] rows [7] = '{13'h1fff, 13'h0ff8, 13'h11f8, 13'h1fc0,
    13'h1bfd, 13'h0e85, 13'h15f2};

  mask_override_and_table_base0 mask_override_and_table_base0_inst (
    .clk_sys(clk_sys), .rst(rst), .req(req), .resp(resp),
    .nonsecure(nonsecure), .cpu_mode(cpu_mode),
    .secure_write_disable(secure_write_disable), .split_n(split_n),
    .route_mask(route_mask), .abort_pending(pending[2]),
    .irq_pending(pending[1]), .fiq_pending(pending[0]),
    .take_abort(take_abort), .take_irq(take_irq), .take_fiq(take_fiq),
    .walk_cfg(walk_cfg));

  always #12.5 clk_sys = ~clk_sys;

  ////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    $display("comparisons %0d errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Generous ceiling: the sequence needs well under 400 cycles
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      wrap_up();
    end
  end

  // Request held for exactly the taking edge; the answer stands one cycle
  task automatic access(input logic wr, input logic [3:0] crn,
      input logic [3:0] crm, input logic [2:0] op2, input logic [31:0] wd,
      input logic ex_undef, input logic [31:0] ex_rd);
    @(posedge clk_sys);
    #2;
    req = '{valid: 1'b1, write: wr, op1: SEL_OP1, crn: crn, crm: crm,
      op2: op2, wdata: wd};
    @(posedge clk_sys);
    #2;
    req.valid = 1'b0;
    `CHK({resp.valid, resp.undef, resp.rdata}, {1'b1, ex_undef, ex_rd})
  endtask

  task automatic mo(input logic wr, input logic [31:0] wd,
      input logic ex_undef, input logic [31:0] ex_rd);
    access(wr, SEL_MO_CRN, SEL_MO_CRM, SEL_MO_OP2, wd, ex_undef, ex_rd);
  endtask

  task automatic tb(input logic wr, input logic [31:0] wd,
      input logic ex_undef, input logic [31:0] ex_rd);
    access(wr, SEL_TB_CRN, SEL_TB_CRM, SEL_TB_OP2, wd, ex_undef, ex_rd);
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] wd;
    repeat (16) @(posedge clk_sys);
    #2;
    rst = 1'b0;
    `CHK({resp, take_abort, take_irq, take_fiq, walk_cfg}, '0)
    mo(1'b0, 32'h0, 1'b0, 32'h0000_0000);
    tb(1'b0, 32'h0, 1'b0, 32'h0000_0000);
    $display("reset test done");
    for (int i = 0; i < 7; i++) begin
      nonsecure = 1'b0;
      mo(1'b1, {23'h0, rows[i][5:3], 6'h0}, 1'b0, 32'h0);
      nonsecure = rows[i][12];
      route_mask = {rows[i][11:9], rows[i][8:6]};
      pending = 3'h7;
      repeat (2) @(posedge clk_sys);
      #2;
      `CHK({take_abort, take_irq, take_fiq}, rows[i][2:0])
    end
    route_mask = '0;
    pending = 3'h0;
    repeat (2) @(posedge clk_sys);
    #2;
    `CHK({take_abort, take_irq, take_fiq}, 3'h0)
    $display("exception rows done");
    nonsecure = 1'b0;
    cpu_mode = MODE_USER;
    mo(1'b1, 32'h0000_01c0, 1'b1, 32'h0);
    mo(1'b0, 32'h0, 1'b1, 32'h0);
    cpu_mode = 5'h13;
    nonsecure = 1'b1;
    mo(1'b1, 32'h0000_0000, 1'b1, 32'h0);
    nonsecure = 1'b0;
    mo(1'b0, 32'h0, 1'b0, 32'h0000_0180);
    $display("override access test done");
    tb(1'b1, 32'hffff_ffff, 1'b0, 32'h0);
    tb(1'b0, 32'h0, 1'b0, 32'hffff_ffdb);
    `CHK(walk_cfg, {32'hffff_c000, 2'h3, 2'h3, 1'b1, 1'b1})
    split_n = 3'h7;
    tb(1'b0, 32'h0, 1'b0, 32'hffff_ffdb);
    `CHK(walk_cfg.base, 32'hffff_ff80)
    for (int c = 0; c < 4; c++) begin
      wd = 32'h1234_5680 | (c << 3) | (c >> 1) | ((c & 1) << 6) | (c & 2);
      tb(1'b1, wd | 32'h0000_0004, 1'b0, 32'h0);
      tb(1'b0, 32'h0, 1'b0, wd);
      `CHK(walk_cfg.base, 32'h1234_5680)
      `CHK(walk_cfg[5:0], {c[1:0], c[1:0], c[0], c[1]})
    end
    $display("attribute test done");
    nonsecure = 1'b1;
    tb(1'b1, 32'h0abc_d000, 1'b0, 32'h0);
    tb(1'b0, 32'h0, 1'b0, 32'h0abc_d000);
    `CHK(walk_cfg, {32'h0abc_d000, 6'h00})
    nonsecure = 1'b0;
    tb(1'b0, 32'h0, 1'b0, 32'h1234_56db);
    $display("banking test done");
    secure_write_disable = 1'b1;
    repeat (3) @(posedge clk_sys);
    tb(1'b1, 32'h0, 1'b1, 32'h0);
    tb(1'b0, 32'h0, 1'b0, 32'h1234_56db);
    nonsecure = 1'b1;
    tb(1'b1, 32'h0000_0080, 1'b0, 32'h0);
    tb(1'b0, 32'h0, 1'b0, 32'h0000_0080);
    cpu_mode = MODE_USER;
    tb(1'b0, 32'h0, 1'b1, 32'h0);
    cpu_mode = 5'h13;
    access(1'b0, 4'h3, 4'h0, 3'h0, 32'h0, 1'b1, 32'h0);
    $display("refusal test done");
    wrap_up();
  end
endmodule
`default_nettype wire
